// file: core/odp_pkg.sv
// shared constants for the output driver protection control block
`default_nettype none

package odp_pkg;
  // clocking: 250 MHz core clock, 1 us tick
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W         = 10;

  // channel counts
  localparam int NUM_OUT    = 11;
  localparam int NUM_BRIDGE = 6;
  localparam int NUM_DRV    = NUM_OUT + NUM_BRIDGE;
  localparam int NUM_PINS   = 3 + 2 * NUM_OUT + 4;

  // timing figures in microseconds
  localparam int WAKE_VALID_US          = 10;
  localparam int STANDBY_TIMEOUT_US     = 256;
  localparam int DRV_ENABLE_US          = 256;
  localparam int DIAG_FILTER_US         = 32;
  localparam int OPEN_LOAD_FILTER_US    = 1000;
  localparam int OVERCURRENT_FILTER_US  = 55;
  localparam int MONITOR_BLANK_US       = 64;
  localparam int PWM_MIN_OFF_US         = 256;
  localparam int CROSS_CURRENT_US       = 8;
  localparam int OCR_OFF_LOW_DUTY_US    = 400;
  localparam int OCR_OFF_HIGH_DUTY_US   = 165;

  // outputs 4, 7 and 9 follow the second pwm input
  localparam logic [NUM_OUT-1:0] PWM_B_MASK = 11'h290;

  // reset values
  localparam logic [1:0] MODE_RESET = 2'h0;

  typedef enum logic [1:0] {
    ODP_STANDBY = 2'h0,
    ODP_WAKE    = 2'h1,
    ODP_ACTIVE  = 2'h3
  } odp_mode_e;
endpackage : odp_pkg

`default_nettype wire

// file: core/odp_persist.sv
// persistence filter: output rises once a condition held for a tick count
`default_nettype none

module odp_persist #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  // control
  input  wire logic         tick_in,
  input  wire logic         clear_in,
  input  wire logic         cond_in,
  input  wire logic [W-1:0] len_in,
  // result
  output logic              seen_out
);

  logic [W-1:0] cnt_r;

  if (W < 2)
  begin : g_chk
    $error("odp_persist width too small");
  end

  // one extra tick absorbs the partial first tick, so the hold is never short
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || clear_in || !cond_in)
      cnt_r <= '0;
    else if (tick_in && (cnt_r <= len_in))
      cnt_r <= cnt_r + W'(1);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || clear_in)
      seen_out <= 1'b0;
    else
      seen_out <= cond_in && (cnt_r > len_in);
  end

endmodule : odp_persist

`default_nettype wire

// file: core/odp_output_driver_protection_control.sv
// mode sequencing, diagnostics and output gating of the load driver
`default_nettype none

module odp_output_driver_protection_control #(
  parameter logic [9:0] WAKE_VALID_US         = 10'(odp_pkg::WAKE_VALID_US),
  parameter logic [9:0] STANDBY_TIMEOUT_US    = 10'(odp_pkg::STANDBY_TIMEOUT_US),
  parameter logic [9:0] DRV_ENABLE_US         = 10'(odp_pkg::DRV_ENABLE_US),
  parameter logic [9:0] DIAG_FILTER_US        = 10'(odp_pkg::DIAG_FILTER_US),
  parameter logic [9:0] OPEN_LOAD_FILTER_US   = 10'(odp_pkg::OPEN_LOAD_FILTER_US),
  parameter logic [9:0] OVERCURRENT_FILTER_US = 10'(odp_pkg::OVERCURRENT_FILTER_US),
  parameter logic [9:0] MONITOR_BLANK_US      = 10'(odp_pkg::MONITOR_BLANK_US),
  parameter logic [9:0] PWM_MIN_OFF_US        = 10'(odp_pkg::PWM_MIN_OFF_US),
  parameter logic [9:0] CROSS_CURRENT_US      = 10'(odp_pkg::CROSS_CURRENT_US),
  parameter logic [9:0] OCR_OFF_LOW_DUTY_US   = 10'(odp_pkg::OCR_OFF_LOW_DUTY_US),
  parameter logic [9:0] OCR_OFF_HIGH_DUTY_US  = 10'(odp_pkg::OCR_OFF_HIGH_DUTY_US)
) (
  // clock and logic supply reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  // pins from the host side, asynchronous
  input  wire logic        chip_select_low_in,
  input  wire logic        pwm_input_a_in,
  input  wire logic        monitor_pwm_b_pin_in,
  // control bits from the serial register file
  input  wire logic        enable_cmd_in,
  input  wire logic [10:0] drive_hs_in,
  input  wire logic [5:0]  drive_ls_in,
  input  wire logic [10:0] pwm_en_in,
  input  wire logic [10:0] ocr_en_in,
  input  wire logic        ocr_high_duty_in,
  input  wire logic        supply_rec_dis_in,
  input  wire logic [3:0]  monitor_sel_in,
  // status clear strobes from the serial register file
  input  wire logic [10:0] clr_oc_in,
  input  wire logic [10:0] clr_ol_in,
  input  wire logic        clr_tw_in,
  input  wire logic        clr_tsd_in,
  input  wire logic        clr_supply_in,
  // analog comparators, asynchronous
  input  wire logic [10:0] oc_det_in,
  input  wire logic [10:0] ol_det_in,
  input  wire logic        uv_det_in,
  input  wire logic        ov_det_in,
  input  wire logic        tw_det_in,
  input  wire logic        tsd_det_in,
  // mode and supply outputs
  output logic [1:0]       mode_out,
  output logic             txn_valid_out,
  output logic             charge_pump_on_out,
  output logic             stage_hiz_out,
  // power stage drive
  output logic [10:0]      hs_on_out,
  output logic [5:0]       ls_on_out,
  output logic [5:0]       fast_off_out,
  // current monitor pin
  output logic             current_image_output_out,
  output logic             monitor_pwm_b_oe_n_out,
  output logic             monitor_blank_out,
  // status flags
  output logic [10:0]      oc_flag_out,
  output logic [10:0]      ol_flag_out,
  output logic             uv_flag_out,
  output logic             ov_flag_out,
  output logic             tw_flag_out,
  output logic             tsd_flag_out
);

  localparam int NO = odp_pkg::NUM_OUT;
  localparam int NB = odp_pkg::NUM_BRIDGE;
  localparam int ND = odp_pkg::NUM_DRV;
  localparam int NP = odp_pkg::NUM_PINS;
  localparam int TW = odp_pkg::TMR_W;
  localparam logic [TW-1:0] OFF_SAT = PWM_MIN_OFF_US + TW'(1);

  if (CROSS_CURRENT_US >= PWM_MIN_OFF_US || WAKE_VALID_US >= STANDBY_TIMEOUT_US)
  begin : g_chk
    $error("odp timing parameters out of order");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and 1 us tick

  logic [NP-1:0] pin_meta_r;
  logic [NP-1:0] pin_s_r;
  logic          cs_s;
  logic          pwm_a_s;
  logic          pwm_b_s;
  logic [NO-1:0] oc_s;
  logic [NO-1:0] ol_s;
  logic          uv_s;
  logic          ov_s;
  logic          tw_s;
  logic          tsd_s;

  always_ff @(posedge core_clk_in)
  begin
    pin_meta_r <= {chip_select_low_in, pwm_input_a_in, monitor_pwm_b_pin_in, oc_det_in,
                   ol_det_in, uv_det_in, ov_det_in, tw_det_in, tsd_det_in};
    pin_s_r    <= pin_meta_r;
  end

  assign {cs_s, pwm_a_s, pwm_b_s, oc_s, ol_s, uv_s, ov_s, tw_s, tsd_s} = pin_s_r;

  logic [8:0] div_r;
  logic       tick_r;

  // all durations count this tick, not the core clock
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || div_r == 9'(odp_pkg::TICK_CYC - 1))
      div_r <= '0;
    else
      div_r <= div_r + 9'h1;
    tick_r <= !reset_in && (div_r == 9'(odp_pkg::TICK_CYC - 1));
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode sequencing

  odp_pkg::odp_mode_e mode_r;
  logic [TW-1:0]      mode_tmr_r;
  logic [TW-1:0]      drv_tmr_r;
  logic               drv_en_r;
  logic               clear_all;

  // standby timeout wipes latched state just like the supply reset
  assign clear_all = reset_in ||
                     (mode_r == odp_pkg::ODP_WAKE && mode_tmr_r > STANDBY_TIMEOUT_US &&
                      !enable_cmd_in);

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      mode_r <= odp_pkg::odp_mode_e'(odp_pkg::MODE_RESET);
    else
      case (mode_r)
        // synced select pin is active low: a low level is a wake request
        odp_pkg::ODP_STANDBY:
          if (!cs_s)
            mode_r <= odp_pkg::ODP_WAKE;
        odp_pkg::ODP_WAKE:
          if (enable_cmd_in && txn_valid_out)
            mode_r <= odp_pkg::ODP_ACTIVE;
          else if (clear_all)
            mode_r <= odp_pkg::ODP_STANDBY;
        odp_pkg::ODP_ACTIVE:
          if (!enable_cmd_in)
            mode_r <= odp_pkg::ODP_WAKE;
        default:
          mode_r <= odp_pkg::ODP_STANDBY;
      endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || mode_r != odp_pkg::ODP_WAKE)
      mode_tmr_r <= '0;
    else if (tick_r && mode_tmr_r <= STANDBY_TIMEOUT_US)
      mode_tmr_r <= mode_tmr_r + TW'(1);
  end

  // transactions before the analog part settles are ignored
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      txn_valid_out <= 1'b0;
    else
      txn_valid_out <= (mode_r == odp_pkg::ODP_ACTIVE) ||
                       (mode_r == odp_pkg::ODP_WAKE && mode_tmr_r > WAKE_VALID_US);
  end

  // count starts when select returns high after enabling
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || mode_r != odp_pkg::ODP_ACTIVE)
      drv_tmr_r <= '0;
    else if (tick_r && (cs_s || drv_tmr_r != '0) && drv_tmr_r <= DRV_ENABLE_US)
      drv_tmr_r <= drv_tmr_r + TW'(1);
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      drv_en_r           <= 1'b0;
      charge_pump_on_out <= 1'b0;
    end
    else
    begin
      drv_en_r           <= mode_r == odp_pkg::ODP_ACTIVE && drv_tmr_r > DRV_ENABLE_US;
      charge_pump_on_out <= mode_r == odp_pkg::ODP_ACTIVE;
    end
  end

  assign mode_out = mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // global diagnostics: supply and temperature

  logic [3:0] glob_seen;
  logic       uv_hold;
  logic       ov_hold;
  logic       all_off;

  odp_persist #(.W(TW)) u_uv (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .tick_in(tick_r), .clear_in(clear_all), .cond_in(uv_s), .len_in(DIAG_FILTER_US),
    .seen_out(glob_seen[0]));
  odp_persist #(.W(TW)) u_ov (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .tick_in(tick_r), .clear_in(clear_all), .cond_in(ov_s), .len_in(DIAG_FILTER_US),
    .seen_out(glob_seen[1]));
  odp_persist #(.W(TW)) u_tw (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .tick_in(tick_r), .clear_in(clear_all), .cond_in(tw_s), .len_in(DIAG_FILTER_US),
    .seen_out(glob_seen[2]));
  odp_persist #(.W(TW)) u_tsd (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .tick_in(tick_r), .clear_in(clear_all), .cond_in(tsd_s), .len_in(DIAG_FILTER_US),
    .seen_out(glob_seen[3]));

  // set beats clear; temperature clears only once the comparator is quiet
  always_ff @(posedge core_clk_in)
  begin
    if (clear_all)
    begin
      uv_flag_out  <= 1'b0;
      ov_flag_out  <= 1'b0;
      tw_flag_out  <= 1'b0;
      tsd_flag_out <= 1'b0;
    end
    else
    begin
      uv_flag_out  <= glob_seen[0] || (uv_flag_out && !clr_supply_in);
      ov_flag_out  <= glob_seen[1] || (ov_flag_out && !clr_supply_in);
      tw_flag_out  <= glob_seen[2] || (tw_flag_out && !(clr_tw_in && !tw_s));
      tsd_flag_out <= glob_seen[3] || (tsd_flag_out && !(clr_tsd_in && !tsd_s));
    end
  end

  // with recovery disabled a flag keeps the stages off until cleared
  assign uv_hold = glob_seen[0] || (supply_rec_dis_in && uv_flag_out);
  assign ov_hold = glob_seen[1] || (supply_rec_dis_in && ov_flag_out);

  // warning and open load deliberately absent here
  assign all_off = !drv_en_r || tsd_flag_out || uv_hold || ov_hold;

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      stage_hiz_out <= 1'b1;
    else
      stage_hiz_out <= !drv_en_r || uv_hold || ov_hold;
  end

  ////////////////////////////////////////////////////////////////////////////
  // per output diagnostics and over-current recovery

  logic [NO-1:0] oc_seen;
  logic [NO-1:0] ol_seen;
  logic [NO-1:0] oc_block_r;
  logic [ND-1:0] on_r;
  logic [NO-1:0] out_on;

  assign out_on = on_r[NO-1:0] | {{(NO-NB){1'b0}}, on_r[ND-1:NO]};

  for (genvar o = 0; o < NO; o++)
  begin : g_out
    logic [TW-1:0] rec_tmr_r;
    logic [TW-1:0] rec_len;

    assign rec_len = ocr_high_duty_in ? OCR_OFF_HIGH_DUTY_US : OCR_OFF_LOW_DUTY_US;

    odp_persist #(.W(TW)) u_oc (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .tick_in(tick_r), .clear_in(clear_all), .cond_in(oc_s[o]),
      .len_in(OVERCURRENT_FILTER_US), .seen_out(oc_seen[o]));
    odp_persist #(.W(TW)) u_ol (.core_clk_in(core_clk_in), .reset_in(reset_in),
      .tick_in(tick_r), .clear_in(clear_all), .cond_in(ol_s[o] && out_on[o]),
      .len_in(OPEN_LOAD_FILTER_US), .seen_out(ol_seen[o]));

    always_ff @(posedge core_clk_in)
    begin
      if (clear_all)
      begin
        oc_flag_out[o] <= 1'b0;
        ol_flag_out[o] <= 1'b0;
      end
      else
      begin
        oc_flag_out[o] <= oc_seen[o] || (oc_flag_out[o] && !clr_oc_in[o]);
        ol_flag_out[o] <= ol_seen[o] || (ol_flag_out[o] && !clr_ol_in[o]);
      end
    end

    always_ff @(posedge core_clk_in)
    begin
      if (clear_all)
      begin
        oc_block_r[o] <= 1'b0;
        rec_tmr_r     <= '0;
      end
      else if (oc_seen[o])
      begin
        oc_block_r[o] <= 1'b1;
        rec_tmr_r     <= '0;
      end
      else if (oc_block_r[o] && ocr_en_in[o])
      begin
        if (tick_r && rec_tmr_r > rec_len)
          oc_block_r[o] <= 1'b0;
        else if (tick_r)
          rec_tmr_r <= rec_tmr_r + TW'(1);
      end
      else if (oc_block_r[o] && !oc_flag_out[o])
        oc_block_r[o] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver gating: pwm, minimum off time, cross-current delay

  logic [ND-1:0] base;
  logic [ND-1:0] on_nxt;
  logic [TW-1:0] off_cnt_r [ND];

  for (genvar d = 0; d < ND; d++)
  begin : g_drv
    localparam int O   = (d < NO) ? d : d - NO;
    localparam int OPP = (d < NB) ? d + NO : ((d >= NO) ? d - NO : d);
    localparam bit BRG = (d < NB) || (d >= NO);
    logic pwm_sig;
    logic ok_pwm;
    logic ok_x;

    assign pwm_sig = odp_pkg::PWM_B_MASK[O] ? pwm_b_s : pwm_a_s;
    assign base[d] = ((d < NO) ? drive_hs_in[O] : drive_ls_in[O]) &&
                     (!pwm_en_in[O] || pwm_sig) && !oc_block_r[O] && !all_off;
    // stops re-firing on the falling slope of a pwm edge
    assign ok_pwm  = !pwm_en_in[O] || on_r[d] || off_cnt_r[d] > PWM_MIN_OFF_US;
    // opposite side must be off for the full delay, never both requested
    assign ok_x    = !BRG || (!base[OPP] && !on_r[OPP] && off_cnt_r[OPP] > CROSS_CURRENT_US);
    assign on_nxt[d] = base[d] && ok_pwm && (on_r[d] || ok_x);

    always_ff @(posedge core_clk_in)
    begin
      if (reset_in)
      begin
        on_r[d]      <= 1'b0;
        off_cnt_r[d] <= OFF_SAT;
      end
      else
      begin
        on_r[d] <= on_nxt[d];
        if (on_r[d])
          off_cnt_r[d] <= '0;
        else if (tick_r && off_cnt_r[d] < OFF_SAT)
          off_cnt_r[d] <= off_cnt_r[d] + TW'(1);
      end
    end
  end

  // fast turn-off while the just-released side still decays
  for (genvar b = 0; b < NB; b++)
  begin : g_brg
    always_ff @(posedge core_clk_in)
    begin
      if (reset_in)
        fast_off_out[b] <= 1'b0;
      else
        fast_off_out[b] <= (on_nxt[b] && off_cnt_r[b+NO] < OFF_SAT) ||
                           (on_nxt[b+NO] && off_cnt_r[b] < OFF_SAT);
    end
  end

  assign hs_on_out = on_r[NO-1:0];
  assign ls_on_out = on_r[ND-1:NO];

  ////////////////////////////////////////////////////////////////////////////
  // current monitor mux and blanking

  logic [3:0]    mon_sel_r;
  logic          mon_on_d_r;
  logic          mon_on;
  logic          mon_valid;
  logic [TW-1:0] blank_tmr_r;

  // codes above the last output select nothing; pin stays undriven
  assign mon_valid = mon_sel_r < 4'(NO);
  assign mon_on    = mon_valid && on_r[mon_sel_r];

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      mon_sel_r   <= 4'hF;
      mon_on_d_r  <= 1'b0;
      blank_tmr_r <= '0;
    end
    else
    begin
      mon_sel_r  <= monitor_sel_in;
      mon_on_d_r <= mon_on;
      if (!mon_on || !mon_on_d_r || mon_sel_r != monitor_sel_in)
        blank_tmr_r <= '0;
      else if (tick_r && blank_tmr_r <= MONITOR_BLANK_US)
        blank_tmr_r <= blank_tmr_r + TW'(1);
    end
  end

  // pin is shared with pwm b: any pwm b user turns the image off
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      monitor_blank_out        <= 1'b1;
      current_image_output_out <= 1'b0;
      monitor_pwm_b_oe_n_out   <= 1'b1;
    end
    else
    begin
      monitor_blank_out        <= blank_tmr_r <= MONITOR_BLANK_US;
      current_image_output_out <= mon_on && blank_tmr_r > MONITOR_BLANK_US &&
                                  !(|(pwm_en_in & odp_pkg::PWM_B_MASK));
      monitor_pwm_b_oe_n_out   <= !(mon_on && blank_tmr_r > MONITOR_BLANK_US &&
                                    !(|(pwm_en_in & odp_pkg::PWM_B_MASK)));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence seq_oc_locked;
    oc_flag_out[0] && !ocr_en_in[0] && !oc_seen[0];
  endsequence

  sequence seq_pwm_a_low;
    pwm_en_in[0] && !pwm_a_s;
  endsequence

  AST_WAKE_ON_SELECT: assert property (
    mode_r == odp_pkg::ODP_STANDBY && !cs_s |=> mode_r == odp_pkg::ODP_WAKE)
    else $error("select low did not wake the device");
  AST_TXN_AFTER_WAIT: assert property (
    $rose(txn_valid_out) |-> $past(mode_tmr_r) > WAKE_VALID_US || mode_r == odp_pkg::ODP_ACTIVE)
    else $error("transaction window opened early");
  AST_TIMEOUT_CLEARS: assert property (
    clear_all |=> mode_r == odp_pkg::ODP_STANDBY && !tw_flag_out && oc_flag_out == '0)
    else $error("timeout did not clear state");
  AST_DRIVE_AFTER_DELAY: assert property (
    (|on_r) |-> $past(drv_tmr_r, 2) > DRV_ENABLE_US && $past(charge_pump_on_out))
    else $error("driver on before enable delay");
  AST_OC_FILTERED: assert property (
    $rose(oc_flag_out[0]) |-> $past(oc_s[0], 2) && $past(oc_s[0], 3))
    else $error("over-current flag without filtered cause");
  AST_OC_STAYS_OFF: assert property (
    seq_oc_locked ##1 !clr_oc_in[0] |=> !on_r[0] && !on_r[NO])
    else $error("driver back on before host clear");
  AST_TSD_ALL_OFF: assert property (
    tsd_flag_out |=> on_r == '0)
    else $error("driver on during thermal shutdown");
  AST_OV_HIZ: assert property (
    glob_seen[1] |=> stage_hiz_out && on_r == '0)
    else $error("overvoltage did not tristate outputs");
  AST_PWM_GATE: assert property (
    seq_pwm_a_low |=> !on_r[0])
    else $error("pwm low did not gate output");
  AST_CLEAR_KEEPS: assert property (
    oc_seen[0] && clr_oc_in[0] |=> oc_flag_out[0] && oc_block_r[0])
    else $error("flag cleared while fault present");
  AST_BRIDGE_EXCL: assert property (
    !(on_r[0] && on_r[NO]))
    else $error("both sides of a bridge on");

endmodule : odp_output_driver_protection_control

`default_nettype wire

// file: verif/odp_host_model.sv
// host model: drives the select pin and the enable bit
`default_nettype none
module odp_host_model (
  // clock and device status
  input  wire logic core_clk_in,
  input  wire logic txn_valid_in,
  // to device
  output logic      chip_select_low_out,
  output logic      enable_cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    chip_select_low_out = 1'b1;
    enable_cmd_out = 1'b0;
  end
  // one frame; the enable write waits for the valid window
  task automatic frame(input bit en);
    int n;
    n = 0;
    @(negedge core_clk_in);
    chip_select_low_out = 1'b0;
    while (txn_valid_in !== 1'b1 && n < 20000)
    begin
      @(negedge core_clk_in);
      n++;
    end
    // oscillation guard bit rides on this write; no pin for it here
    enable_cmd_out = en;
    repeat (250) @(negedge core_clk_in);
    chip_select_low_out = 1'b1;
  endtask : frame
endmodule : odp_host_model
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the output driver protection control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DF = 2;
  localparam int OC = 3;
  localparam int PM = 6;
  logic core_clk_in = 1'b0, reset_in = 1'b1, pwm_input_a_in = 1'b1, pwm_b = 1'b1;
  logic ocr_high_duty_in = 1'b0, supply_rec_dis_in = 1'b0, clr_tw_in = 1'b0, clr_tsd_in = 1'b0;
  logic clr_supply_in = 1'b0, uv_det_in = 1'b0, ov_det_in = 1'b0, tw_det_in = 1'b0;
  logic tsd_det_in = 1'b0, img, oe_n, uv_flag_out, ov_flag_out, tw_flag_out, tsd_flag_out;
  logic [10:0] drive_hs_in = '0, pwm_en_in = '0, ocr_en_in = '0, clr_oc_in = '0, oc_det_in = '0;
  logic [10:0] ol_det_in = '0, clr_ol_in = '0, hs_on_out, oc_flag_out, ol_flag_out;
  logic [5:0]  drive_ls_in = '0, ls_on_out, fast_off_out;
  logic        blank;
  logic [3:0]  monitor_sel_in = 4'hF;
  logic [1:0]  mode_out;
  logic        chip_select_low_in, enable_cmd_in, txn_valid_out, charge_pump_on_out, stage_hiz_out;
  wire logic   monitor_pwm_b_pin_in = oe_n ? pwm_b : img;
  int          seed, k, checks = 0, miscompares = 0, cycles = 0;
  always #2 core_clk_in = ~core_clk_in;
  ////////////////////////////////////////////////////////////////////////////
  odp_output_driver_protection_control #(.WAKE_VALID_US(10'h2), .STANDBY_TIMEOUT_US(10'h6),
    .DRV_ENABLE_US(10'h4), .DIAG_FILTER_US(10'(DF)), .OVERCURRENT_FILTER_US(10'(OC)),
    .CROSS_CURRENT_US(10'h2), .PWM_MIN_OFF_US(10'(PM)), .OPEN_LOAD_FILTER_US(10'(DF))) uut (
    .core_clk_in, .reset_in, .chip_select_low_in, .pwm_input_a_in, .monitor_pwm_b_pin_in,
    .enable_cmd_in, .drive_hs_in, .drive_ls_in, .pwm_en_in, .ocr_en_in, .ocr_high_duty_in,
    .supply_rec_dis_in, .monitor_sel_in, .clr_oc_in, .clr_ol_in, .clr_tw_in, .clr_tsd_in,
    .clr_supply_in, .oc_det_in, .ol_det_in, .uv_det_in, .ov_det_in, .tw_det_in, .tsd_det_in,
    .mode_out, .txn_valid_out, .charge_pump_on_out, .stage_hiz_out, .hs_on_out, .ls_on_out,
    .fast_off_out, .current_image_output_out(img), .monitor_pwm_b_oe_n_out(oe_n),
    .monitor_blank_out(blank), .oc_flag_out, .ol_flag_out, .uv_flag_out, .ov_flag_out,
    .tw_flag_out, .tsd_flag_out);
  odp_host_model host (.core_clk_in, .txn_valid_in(txn_valid_out),
    .chip_select_low_out(chip_select_low_in), .enable_cmd_out(enable_cmd_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [10:0] off_one(input int n);
    return 11'h7FF & ~(11'h1 << n);
  endfunction : off_one
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic us(input int n);
    repeat (n * odp_pkg::TICK_CYC) @(negedge core_clk_in);
  endtask : us
  // clear strobes stay up one cycle only
  task automatic tog();
    @(negedge core_clk_in);
    {clr_oc_in, clr_ol_in, clr_tw_in, clr_tsd_in, clr_supply_in} = '0;
    us(1);
  endtask : tog
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done
  // run ceiling well above the roughly 110 us the sequence needs
  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 50000)
    begin
      miscompares++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hB60FB81B;
    repeat (5) @(negedge core_clk_in);
    reset_in = 1'b0;
    chk({mode_out, stage_hiz_out, txn_valid_out, blank, hs_on_out}, 16'h2800);
    host.frame(1'b0);
    chk({mode_out, txn_valid_out}, {odp_pkg::ODP_WAKE, 1'b1});
    us(9);
    chk(mode_out, odp_pkg::ODP_STANDBY);
    $display("standby timeout test done");
    host.frame(1'b1);
    us(6);
    chk({mode_out, charge_pump_on_out, stage_hiz_out}, {odp_pkg::ODP_ACTIVE, 2'h2});
    repeat (4)
    begin
      drive_hs_in = 11'($random(seed));
      monitor_sel_in = 4'({$random(seed)} % 11);
      us(1);
      chk({ls_on_out, hs_on_out}, {6'h0, drive_hs_in});
    end
    // all on first, so no random off leaves a minimum off time pending
    drive_hs_in = 11'h7FF;
    us(1);
    chk(hs_on_out, 11'h7FF);
    {pwm_en_in, pwm_input_a_in} = {11'h7FF, 1'b0};
    us(1);
    chk(hs_on_out, odp_pkg::PWM_B_MASK);
    pwm_input_a_in = 1'b1;
    us(1);
    chk(hs_on_out, odp_pkg::PWM_B_MASK);
    us(PM + 2);
    chk(hs_on_out, 11'h7FF);
    pwm_en_in = '0;
    $display("drive and pwm test done");
    k = {$random(seed)} % 11;
    oc_det_in[k] = 1'b1;
    us(OC + 3);
    chk({oc_flag_out, hs_on_out}, {11'h1 << k, off_one(k)});
    clr_oc_in[k] = 1'b1;
    tog();
    chk({oc_flag_out, hs_on_out}, {11'h1 << k, off_one(k)});
    oc_det_in[k] = 1'b0;
    us(1);
    chk(hs_on_out, off_one(k));
    clr_oc_in[k] = 1'b1;
    tog();
    chk({oc_flag_out, hs_on_out}, {11'h0, 11'h7FF});
    tw_det_in = 1'b1;
    us(DF + 3);
    chk({tw_flag_out, hs_on_out}, {1'b1, 11'h7FF});
    clr_tw_in = 1'b1;
    tog();
    chk(tw_flag_out, 1'b1);
    {tw_det_in, tsd_det_in} = 2'b01;
    us(DF + 3);
    chk({tsd_flag_out, hs_on_out}, {1'b1, 11'h0});
    // comparator must be quiet past its synchroniser before the clear
    tsd_det_in = 1'b0;
    us(1);
    {clr_tw_in, clr_tsd_in} = 2'b11;
    tog();
    chk({tw_flag_out, tsd_flag_out, hs_on_out}, {2'h0, 11'h7FF});
    $display("fault test done");
    for (int i = 0; i < 3; i++)
    begin
      supply_rec_dis_in = (i == 2);
      {uv_det_in, ov_det_in} = 2'(i % 2 + 1);
      us(DF + 3);
      chk({stage_hiz_out, hs_on_out}, {1'b1, 11'h0});
      {uv_det_in, ov_det_in} = 2'b00;
      us(DF + 3);
      chk(hs_on_out, (i == 2) ? 11'h0 : 11'h7FF);
      clr_supply_in = 1'b1;
      tog();
    end
    chk(hs_on_out, 11'h7FF);
    $display("supply test done");
    k = {$random(seed)} % 11;
    drive_hs_in[k] = 1'b0;
    ol_det_in = 11'h7FF;
    us(DF + 3);
    chk({ol_flag_out, hs_on_out}, {2{off_one(k)}});
    {ol_det_in, drive_hs_in} = {11'h0, 11'h7FF};
    us(1);
    clr_ol_in = 11'h7FF;
    tog();
    chk({ol_flag_out, hs_on_out}, {11'h0, 11'h7FF});
    {drive_hs_in[0], drive_ls_in[0]} = 2'b01;
    us(1);
    chk({ls_on_out, hs_on_out[0]}, 7'h0);
    us(4);
    chk({ls_on_out[0], fast_off_out[0], hs_on_out[0]}, 3'h6);
    $display("open load and bridge test done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
